// *** rtl/psc_regs.svh ***
// register offsets, field positions, reset values and timing constants
`ifndef PSC_REGS_SVH
`define PSC_REGS_SVH

// =====================================================
// offsets
`define PSC_SEL_OFS 8'h1e
`define PSC_FREQ_OFS 8'h1f
`define PSC_CAP1_OFS 8'h20
`define PSC_CAP2_OFS 8'h21

// =====================================================
// fields and reset values
`define PSC_SEL_P0 0
`define PSC_SEL_P1 1
`define PSC_SEL_AEN 2
`define PSC_SEL_RST 8'h04
`define PSC_CAP_FRZ 7
`define PSC_CAP_RST 8'h00
`define PSC_FREQ_RST 8'h00

// =====================================================
// timing
`define PSC_OSC_NS 40
`define PSC_CLK_NS 5
`define PSC_OSC_CYC (`PSC_OSC_NS / `PSC_CLK_NS)

`endif

// *** rtl/psc_pkg.sv ***
// types shared by the port select and capability register block
package psc_pkg;

    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_ACK_A, ST_REG,
        ST_ACK_W, ST_WR, ST_RD, ST_RACK
    } psc_st_e;

    typedef struct packed {
        logic [2:0] fast_ctrl_channel_mode;
        logic freq_training_request;
        logic eq_training_request;
        logic two_link_capable;
        logic channel_secondary;
        logic video24_with_hd_sound;
        logic forward_frame_gpio_support;
    } psc_cap_s;

endpackage

// *** rtl/psc_port_select_regs.sv ***
// port select, frequency counter and remote capability registers
//
// Behaviour
// - select bit 2 (reset 1) enables a second target address, base plus one
// - second address reaches second-port and shared registers
// - second-port select: primary writes port1 and shared, reads port1
// - first-port select: primary writes port0 and shared, reads port0
// - both selects set reads port1; host clears it to read port0
// - port selects ignored while second address enable is set
// - writing counter starts a window of value times 40 ns oscillator
// - reading counter returns pixel edges of the latest window
// - pixel edge count saturates at 0xff
// - capability freeze bit 7 blocks auto-load, keeps software values
// - unfrozen capabilities load from control channel after receive lock
// - capability bit 6 holds mode bit 0, upper two bits in second reg
// - capability bit 5 requests frequency training pattern
// - capability bit 4 requests equalization training pattern
// - capability bit 3 shows remote two-link support
// - capability bit 2 channel: 0 primary, 1 secondary
// - with second-port select, capabilities reflect port1 receiver
// - mode 000 normal frame, 001/010/011 fast gpio with 1/2/4
// - bits 1 and 0: 24-bit video with hd sound, forward gpio
`include "psc_regs.svh"

module psc_port_select_regs #(
    parameter int OSC_CYC = `PSC_OSC_CYC
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [6:0] base_target_address,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n,
    input wire logic pix_clk_i,
    input wire logic [1:0] rx_lock,
    input wire logic [1:0] cap_load,
    input wire psc_pkg::psc_cap_s cap_in [2],
    output psc_pkg::psc_cap_s cap_out [2]
);

    if (OSC_CYC < 1 || OSC_CYC > 15) begin : g_chk
        $error("OSC_CYC out of range");
    end

    // =====================================================
    // input synchronisers
    logic [2:0] scl_s_r, sda_s_r, pix_s_r;
    logic scl_f_r, sda_f_r, pix_f_r;

    always_ff @(posedge core_clk) begin
        scl_s_r <= {scl_s_r[1:0], scl_i};
        sda_s_r <= {sda_s_r[1:0], sda_i};
        pix_s_r <= {pix_s_r[1:0], pix_clk_i};
    end

    wire scl_ok = scl_s_r[1] == scl_s_r[2];
    wire sda_ok = sda_s_r[1] == sda_s_r[2];
    wire pix_ok = pix_s_r[1] == pix_s_r[2];

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            scl_f_r <= 1'b1;
            sda_f_r <= 1'b1;
            pix_f_r <= 1'b0;
        end else begin
            if (scl_ok) scl_f_r <= scl_s_r[2];
            if (sda_ok) sda_f_r <= sda_s_r[2];
            if (pix_ok) pix_f_r <= pix_s_r[2];
        end
    end

    wire scl_rise = scl_ok & scl_s_r[2] & ~scl_f_r;
    wire scl_fall = scl_ok & ~scl_s_r[2] & scl_f_r;
    wire sda_rise = sda_ok & sda_s_r[2] & ~sda_f_r;
    wire sda_fall = sda_ok & ~sda_s_r[2] & sda_f_r;
    wire i2c_start = sda_fall & scl_f_r;
    wire i2c_stop = sda_rise & scl_f_r;
    wire pix_rise = pix_ok & pix_s_r[2] & ~pix_f_r;

    // =====================================================
    // registers and port steering
    psc_pkg::psc_st_e st_r;
    logic [6:0] addr_r;
    logic [3:0] bit_r;
    logic [7:0] sh_r, ptr_r, sel_r;
    logic rw_r, via_sec_r, oe_n_r;
    logic [7:0] cap1_r [2];
    logic [1:0] cap2_r [2];
    logic [7:0] freq_res_r;

    wire sel_aen = sel_r[`PSC_SEL_AEN];
    wire [6:0] addr_sec = addr_r + 7'h01;
    wire hit_pri = sh_r[7:1] == addr_r;
    wire hit_sec = sel_aen & (sh_r[7:1] == addr_sec);
    wire addr_done = st_r == psc_pkg::ST_ADDR & scl_fall & bit_r == 4'h8;
    wire wr_go = st_r == psc_pkg::ST_WR & scl_fall & bit_r == 4'h8;

    // selects only act on the primary address without enable
    wire pri_sel = ~via_sec_r & ~sel_aen;
    wire rd_p1 = via_sec_r | (pri_sel & sel_r[`PSC_SEL_P1]);
    wire wr_p1 = rd_p1;
    wire wr_p0 = ~via_sec_r & (~pri_sel | sel_r[`PSC_SEL_P0]
                 | ~sel_r[`PSC_SEL_P1]);

    wire wr_sel = wr_go & ptr_r == `PSC_SEL_OFS;
    wire wr_freq = wr_go & ptr_r == `PSC_FREQ_OFS;
    wire wr_cap1 = wr_go & ptr_r == `PSC_CAP1_OFS;
    wire wr_cap2 = wr_go & ptr_r == `PSC_CAP2_OFS;

    wire [7:0] rd_data =
        ptr_r == `PSC_SEL_OFS ? sel_r :
        ptr_r == `PSC_FREQ_OFS ? freq_res_r :
        ptr_r == `PSC_CAP1_OFS ? cap1_r[rd_p1] :
        ptr_r == `PSC_CAP2_OFS ? {6'h00, cap2_r[rd_p1]} : 8'h00;

    // =====================================================
    // target state machine
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st_r <= psc_pkg::ST_IDLE;
            addr_r <= base_target_address;
            bit_r <= 4'h0;
            sh_r <= 8'h00;
            ptr_r <= 8'h00;
            rw_r <= 1'b0;
            via_sec_r <= 1'b0;
            oe_n_r <= 1'b1;
        end else if (i2c_stop) begin
            st_r <= psc_pkg::ST_IDLE;
            oe_n_r <= 1'b1;
        end else if (i2c_start) begin
            st_r <= psc_pkg::ST_ADDR;
            bit_r <= 4'h0;
            oe_n_r <= 1'b1;
        end else begin
            unique case (st_r)
                psc_pkg::ST_IDLE: begin
                end
                psc_pkg::ST_ADDR, psc_pkg::ST_REG, psc_pkg::ST_WR: begin
                    if (scl_rise) begin
                        sh_r <= {sh_r[6:0], sda_f_r};
                        bit_r <= bit_r + 4'h1;
                    end else if (scl_fall && bit_r == 4'h8) begin
                        oe_n_r <= 1'b0;
                        st_r <= psc_pkg::ST_ACK_W;
                        if (st_r == psc_pkg::ST_REG) ptr_r <= sh_r;
                        if (st_r == psc_pkg::ST_WR) ptr_r <= ptr_r + 8'h01;
                        if (st_r == psc_pkg::ST_ADDR) begin
                            rw_r <= sh_r[0];
                            via_sec_r <= hit_sec;
                            st_r <= psc_pkg::ST_ACK_A;
                            if (!(hit_pri || hit_sec)) begin
                                oe_n_r <= 1'b1;
                                st_r <= psc_pkg::ST_IDLE;
                            end
                        end
                    end
                end
                psc_pkg::ST_ACK_A: begin
                    if (scl_fall) begin
                        bit_r <= 4'h0;
                        sh_r <= rd_data;
                        oe_n_r <= rw_r ? rd_data[7] : 1'b1;
                        st_r <= rw_r ? psc_pkg::ST_RD : psc_pkg::ST_REG;
                    end
                end
                psc_pkg::ST_ACK_W: begin
                    if (scl_fall) begin
                        bit_r <= 4'h0;
                        oe_n_r <= 1'b1;
                        st_r <= psc_pkg::ST_WR;
                    end
                end
                psc_pkg::ST_RD: begin
                    if (scl_fall) begin
                        bit_r <= bit_r + 4'h1;
                        sh_r <= {sh_r[6:0], 1'b0};
                        oe_n_r <= sh_r[6];
                        if (bit_r == 4'h7) begin
                            oe_n_r <= 1'b1;
                            ptr_r <= ptr_r + 8'h01;
                            st_r <= psc_pkg::ST_RACK;
                        end
                    end
                end
                psc_pkg::ST_RACK: begin
                    if (scl_rise && sda_f_r) begin
                        st_r <= psc_pkg::ST_IDLE;
                    end else if (scl_fall) begin
                        bit_r <= 4'h0;
                        sh_r <= rd_data;
                        oe_n_r <= rd_data[7];
                        st_r <= psc_pkg::ST_RD;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            sda_oe_n <= 1'b1;
            sda_o <= 1'b0;
        end else begin
            sda_oe_n <= oe_n_r;
            sda_o <= 1'b0;
        end
    end

    // =====================================================
    // shared select register
    always_ff @(posedge core_clk) begin
        if (!rst_n) sel_r <= `PSC_SEL_RST;
        else if (wr_sel) sel_r <= {5'h00, sh_r[2:0]};
    end

    // =====================================================
    // pixel frequency counter
    logic [3:0] div_r;
    logic [7:0] win_r, pcnt_r;
    logic busy_r;

    wire tick = div_r == 4'(OSC_CYC - 1);
    wire [7:0] pcnt_nxt = (busy_r & pix_rise & pcnt_r != 8'hff) ?
                          pcnt_r + 8'h01 : pcnt_r;
    wire win_end = busy_r & tick & win_r <= 8'h01;

    always_ff @(posedge core_clk) begin
        if (!rst_n || wr_freq || tick) div_r <= 4'h0;
        else div_r <= div_r + 4'h1;
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            win_r <= 8'h00;
            pcnt_r <= 8'h00;
            busy_r <= 1'b0;
            freq_res_r <= `PSC_FREQ_RST;
        end else if (wr_freq) begin
            win_r <= sh_r;
            pcnt_r <= 8'h00;
            busy_r <= 1'b1;
        end else begin
            pcnt_r <= pcnt_nxt;
            if (busy_r && tick) win_r <= win_r - 8'h01;
            if (win_end) begin
                busy_r <= 1'b0;
                freq_res_r <= pcnt_nxt;
            end
        end
    end

    // =====================================================
    // remote capability registers, one set per port
    function automatic psc_pkg::psc_cap_s cap_unpack(
        input logic [7:0] c1, input logic [1:0] c2);
        cap_unpack = {c2, c1[6:0]};
    endfunction

    for (genvar p = 0; p < 2; p++) begin : g_port
        wire sw_wr = p == 1 ? wr_p1 : wr_p0;
        wire auto_ld = cap_load[p] & rx_lock[p]
                       & ~cap1_r[p][`PSC_CAP_FRZ];
        psc_pkg::psc_cap_s ci;
        assign ci = cap_in[p];

        always_ff @(posedge core_clk) begin
            if (!rst_n) begin
                cap1_r[p] <= `PSC_CAP_RST;
                cap2_r[p] <= 2'h0;
            end else begin
                if (wr_cap1 && sw_wr) cap1_r[p] <= sh_r;
                else if (auto_ld)
                    cap1_r[p] <= {cap1_r[p][7], ci[6:0]};
                if (wr_cap2 && sw_wr) cap2_r[p] <= sh_r[1:0];
                else if (auto_ld) cap2_r[p] <= ci[8:7];
            end
        end

        assign cap_out[p] = cap_unpack(cap1_r[p], cap2_r[p]);
    end

    // =====================================================
    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence s_sec_hit;
        addr_done && hit_sec && !i2c_stop && !i2c_start;
    endsequence

    a_sec_addr_ack: assert property (
        s_sec_hit |=> st_r == psc_pkg::ST_ACK_A ##1 !sda_oe_n)
        else $error("second address not acknowledged");
    a_sec_port_route: assert property (
        s_sec_hit |=> via_sec_r && rd_p1 && !wr_p0)
        else $error("second address not routed to port1");
    a_p1_write: assert property (
        wr_cap1 && wr_p1 |=> cap1_r[1] == $past(sh_r))
        else $error("port1 capability write lost");
    a_p0_write: assert property (
        wr_cap1 && wr_p0 |=> cap1_r[0] == $past(sh_r))
        else $error("port0 capability write lost");
    a_both_sel_read: assert property (
        !via_sec_r && !sel_aen && sel_r[1:0] == 2'h3 |-> rd_p1 && wr_p0)
        else $error("both selects mis-steered");
    a_sel_ignored: assert property (
        !via_sec_r && sel_aen |-> !rd_p1 && wr_p0)
        else $error("selects honoured under enable");
    a_freq_window: assert property (
        wr_freq && sh_r == 8'h01 |=> busy_r [*8] ##1 !busy_r)
        else $error("one-step window not 8 cycles");
    a_freq_hold: assert property (
        busy_r && pcnt_r == 8'hff && !wr_freq |=> pcnt_r == 8'hff)
        else $error("pixel count wrapped");
    a_cap_frozen: assert property (
        cap1_r[0][7] && !(wr_cap1 && wr_p0) |=> $stable(cap1_r[0][6:0]))
        else $error("frozen capabilities changed");
    a_cap_load: assert property (
        g_port[1].auto_ld && !(wr_cap1 && wr_p1)
        |=> cap1_r[1][6:0] == $past(cap_in[1][6:0]))
        else $error("capability auto-load missed");

endmodule // psc_port_select_regs

// *** test/psc_i2c_host.sv ***
// i2c host model that drives the block's target port
module psc_i2c_host (
    input wire logic core_clk,
    input wire logic sda_o,
    input wire logic sda_oe_n,
    output logic scl,
    output logic sda
);
    timeunit 1ns;
    timeprecision 1ps;

    logic pull_r = 1'b0;

    initial scl = 1'b1;

    // open drain: whichever party pulls low wins, else the pull-up
    assign sda = ~pull_r & (sda_oe_n | sda_o);

    // =====================================================
    // bus phases, scl low 12 core cycles, high 8 per bit and 16 for start and stop
    task automatic wt(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    task automatic bit_io(input logic b, output logic s);
        scl <= 1'b0;
        wt(4);
        pull_r <= ~b;
        wt(8);
        scl <= 1'b1;
        wt(4);
        #1 s = sda;
        wt(4);
    endtask

    task automatic start();
        scl <= 1'b0;
        wt(4);
        pull_r <= 1'b0;
        wt(8);
        scl <= 1'b1;
        wt(8);
        pull_r <= 1'b1;
        wt(8);
    endtask

    task automatic stop();
        scl <= 1'b0;
        wt(4);
        pull_r <= 1'b1;
        wt(8);
        scl <= 1'b1;
        wt(8);
        pull_r <= 1'b0;
        wt(8);
    endtask

    // eight data bits msb first, then the acknowledge bit
    task automatic byte_io(input logic [7:0] tx, input logic m,
                           output logic [7:0] rx, output logic s);
        for (int i = 7; i >= 0; i--)
            bit_io(tx[i], rx[i]);
        bit_io(m, s);
    endtask
endmodule // psc_i2c_host

// *** test/port_select_capability_regs_tb_top.sv ***
// self-checking bench for the port select and capability registers
module port_select_capability_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [6:0] BASE = 7'h2c;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic scl, sda, sda_o, sda_oe_n, ak, lk;
    logic pix_run = 1'b0;
    logic pix_clk_i = 1'b0;
    logic [1:0] pix_div = 2'h0;
    logic [1:0] rx_lock = 2'h0;
    logic [1:0] cap_load = 2'h0;
    logic [7:0] rd;
    psc_pkg::psc_cap_s cap_in [2] = '{default: '0};
    psc_pkg::psc_cap_s cap_out [2];
    psc_pkg::psc_cap_s cv, ex;
    int bad_count = 0;
    int checks = 0;
    int cyc = 0;

    always #2.5 core_clk = ~core_clk;

    psc_port_select_regs #(.OSC_CYC(8)) u_dut (
        .core_clk(core_clk), .rst_n(rst_n),
        .base_target_address(BASE), .scl_i(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe_n(sda_oe_n), .pix_clk_i(pix_clk_i),
        .rx_lock(rx_lock), .cap_load(cap_load), .cap_in(cap_in),
        .cap_out(cap_out)
    );

    psc_i2c_host u_host (
        .core_clk(core_clk), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
        .scl(scl), .sda(sda)
    );

    // =====================================================
    // pixel clock, rising edge every 4 core cycles, and timeout
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        pix_div <= pix_div + 2'h1;
        pix_clk_i <= pix_run & pix_div[1];
        if (cyc == 60000) begin
            bad_count++;
            stop_test();
        end
    end

    // =====================================================
    // access tasks
    task automatic check(input string nm, input logic [8:0] seen,
                         input logic [8:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] o, d);
        logic [7:0] x;
        logic s0, s1, s2;
        u_host.start();
        u_host.byte_io({a, 1'b0}, 1'b1, x, s0);
        u_host.byte_io(o, 1'b1, x, s1);
        u_host.byte_io(d, 1'b1, x, s2);
        u_host.stop();
        ak = ~(s0 | s1 | s2);
    endtask

    task automatic rg(input logic [6:0] a, input logic [7:0] o);
        logic [7:0] x;
        logic s0, s1, s2, s3;
        u_host.start();
        u_host.byte_io({a, 1'b0}, 1'b1, x, s0);
        u_host.byte_io(o, 1'b1, x, s1);
        u_host.start();
        u_host.byte_io({a, 1'b1}, 1'b1, x, s2);
        u_host.byte_io(8'hff, 1'b1, rd, s3);
        u_host.stop();
        ak = ~(s0 | s1 | s2);
    endtask

    task automatic rc(input string nm, input logic [6:0] a,
                      input logic [7:0] o, exp);
        rg(a, o);
        check(nm, {1'b0, rd}, {1'b0, exp});
    endtask

    task automatic stop_test();
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // =====================================================
    // main sequence
    initial begin
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge core_clk);
        rc("sel_rst", BASE, 8'h1e, 8'h04);
        rc("freq_rst", BASE, 8'h1f, 8'h00);
        rc("cap1_rst", BASE, 8'h20, 8'h00);
        rc("cap2_rst", BASE, 8'h21, 8'h00);
        rc("unmapped", BASE, 8'h40, 8'h00);
        wr(BASE + 7'h2, 8'h20, 8'h81);
        check("far_nack", {8'h0, ak}, 9'h0);
        // second address enabled: selects have no say on the primary
        wr(BASE + 7'h1, 8'h20, 8'h95);
        check("p1_ack", {8'h0, ak}, 9'h1);
        wr(BASE, 8'h1e, 8'h06);
        wr(BASE, 8'h20, 8'h8a);
        rc("p1_addr", BASE + 7'h1, 8'h20, 8'h95);
        rc("p0_prim", BASE, 8'h20, 8'h8a);
        rc("shared", BASE + 7'h1, 8'h1e, 8'h06);
        // steering through the select bits
        wr(BASE, 8'h1e, 8'h02);
        wr(BASE + 7'h1, 8'h21, 8'h03);
        check("p1_off", {8'h0, ak}, 9'h0);
        rc("p1_sel", BASE, 8'h20, 8'h95);
        wr(BASE, 8'h20, 8'h9c);
        rc("p1_wr", BASE, 8'h20, 8'h9c);
        wr(BASE, 8'h1e, 8'h01);
        rc("p0_sel", BASE, 8'h20, 8'h8a);
        wr(BASE, 8'h20, 8'h83);
        rc("p0_wr", BASE, 8'h20, 8'h83);
        wr(BASE, 8'h1e, 8'h03);
        wr(BASE, 8'h21, 8'h02);
        rc("both_rd", BASE, 8'h20, 8'h9c);
        wr(BASE, 8'h1e, 8'h01);
        rc("both_wr", BASE, 8'h21, 8'h02);
        // port1 unfrozen, port0 stays frozen
        wr(BASE, 8'h1e, 8'h02);
        wr(BASE, 8'h20, 8'h00);
        ex = 9'h100;
        for (int m = 0; m < 5; m++) begin
            lk = (m != 0);
            cv = {1'b0, 2'(m - 1), 6'h2d ^ 6'(m)};
            if (lk)
                ex = cv;
            @(posedge core_clk);
            cap_in[0] <= ~cv;
            cap_in[1] <= cv;
            rx_lock <= {lk, 1'b1};
            cap_load <= 2'h3;
            @(posedge core_clk);
            cap_load <= 2'h0;
            @(posedge core_clk);
            #1;
            check("frozen", cap_out[0], 9'h103);
            check("cap_out1", cap_out[1], ex);
            @(posedge core_clk);
            rc("cap1", BASE, 8'h20, 8'(ex[6:0]));
            rc("cap2", BASE, 8'h21, {6'h0, ex[8:7]});
        end
        // frequency counter
        pix_run <= 1'b1;
        wr(BASE, 8'h1f, 8'h10);
        repeat (200) @(posedge core_clk);
        rg(BASE, 8'h1f);
        check("freq16", {8'h0, rd inside {[8'd31:8'd33]}}, 9'h1);
        wr(BASE, 8'h1f, 8'hff);
        repeat (2100) @(posedge core_clk);
        rc("freq_sat", BASE, 8'h1f, 8'hff);
        // one-step window: two pixel edges in eight core cycles
        wr(BASE, 8'h1f, 8'h01);
        rg(BASE, 8'h1f);
        check("freq1", {8'h0, rd inside {[8'd1:8'd3]}}, 9'h1);
        pix_run <= 1'b0;
        wr(BASE, 8'h1f, 8'h10);
        repeat (200) @(posedge core_clk);
        rc("freq_idle", BASE, 8'h1f, 8'h00);
        stop_test();
    end
endmodule // port_select_capability_regs_tb_top
